// >>> include/ddic_consts.svh
// Constants of the disk data integrity check block
`ifndef DDIC_CONSTS_SVH
`define DDIC_CONSTS_SVH
`define DDIC_ADDR_W 16
`define DDIC_CRC_W 16
`define DDIC_HDR_BITS 32
`define DDIC_CRC_POLY 16'h1021
`define DDIC_ECC_W 56
`define DDIC_ECC_POLY 56'h00_0000_4000_0a05
`define DDIC_BURST_FIX 11
`define DDIC_BURST_DET 22
`define DDIC_SLOTS 4
`define DDIC_SECT_BYTES 512
`define DDIC_PAR_ODD 1'b1
`define DDIC_FIX_BYTES 3
`define DDIC_REV_NS 16667000
`define DDIC_CLK_NS 10
`endif

// >>> include/ddic_pkg.sv
// Types shared by the disk data integrity check block
package ddic_pkg;
    typedef enum logic [2:0] {
        DDIC_IDLE = 3'h0,
        DDIC_HDR = 3'h1,
        DDIC_DATA = 3'h3,
        DDIC_CORR = 3'h2,
        DDIC_FIX = 3'h6
    } ddic_state_t;
    typedef logic [7:0] ddic_byte_t;
endpackage

// >>> include/ddic_lfsr_if.sv
// Control and state of one serial check-code register
`timescale 1ns/1ps
interface ddic_lfsr_if #(parameter int W = 16);
    logic clr;
    logic shift;
    logic din;
    logic gen;
    logic [W-1:0] q;
    modport ctl (output clr, output shift, output din, output gen, input q);
    modport lfsr (input clr, input shift, input din, input gen, output q);
endinterface

// >>> core/ddic_lfsr.sv
// Serial polynomial divider used for header and sector check codes
`timescale 1ns/1ps
`include "ddic_consts.svh"
module ddic_lfsr import ddic_pkg::*; #(
    parameter int W = `DDIC_CRC_W,
    parameter logic [W-1:0] POLY = `DDIC_CRC_POLY
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    ddic_lfsr_if.lfsr lf
);
    logic fb;

    // Generate mode shifts the remainder out with zero feedback
    assign fb = lf.gen ? 1'b0 : (lf.din ^ lf.q[W-1]);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || lf.clr) begin
            lf.q <= '0;
        end else if (lf.shift) begin
            lf.q <= {lf.q[W-2:0], 1'b0} ^ (fb ? POLY : '0);
        end
    end

    a_poly_low_tap: assert property (@(posedge i_clk_sys) POLY[0] == 1'b1)
        else $error("polynomial lacks constant term");
    a_gen_drains: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (lf.shift && lf.gen && !lf.clr) |=> lf.q[0] == 1'b0)
        else $error("generate shift did not insert zero");
endmodule

// >>> core/ddic_core.sv
// Header check, address verify, sector code, buffer parity and sector buffer
`timescale 1ns/1ps
`include "ddic_consts.svh"
module ddic_core import ddic_pkg::*; #(
    parameter int SECT_BYTES = `DDIC_SECT_BYTES,
    parameter int SLOTS = `DDIC_SLOTS,
    parameter logic [`DDIC_CRC_W-1:0] CRC_POLY = `DDIC_CRC_POLY,
    parameter logic [`DDIC_ECC_W-1:0] ECC_POLY = `DDIC_ECC_POLY,
    parameter logic PAR_FITTED = 1'b1,
    parameter logic PAR_ODD = `DDIC_PAR_ODD,
    parameter int REV_CYC = `DDIC_REV_NS / `DDIC_CLK_NS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_op_en,
    input wire logic i_op_write,
    input wire logic i_op_fmt,
    input wire logic [`DDIC_ADDR_W-1:0] i_req_addr,
    input wire logic i_sector_mark,
    input wire logic i_bit_tick,
    input wire logic i_disk_rd_bit,
    output logic o_disk_wr_bit,
    output logic o_disk_wr_gate,
    input wire logic i_host_wr_vld,
    input wire logic [7:0] i_host_wr_data,
    output logic o_host_wr_rdy,
    output logic o_host_rd_vld,
    output logic [7:0] o_host_rd_data,
    input wire logic i_host_rd_rdy,
    output logic o_busy,
    output logic o_sect_done,
    output logic o_hdr_crc_err,
    output logic o_addr_miss,
    output logic o_rev_wait,
    output logic o_ecc_fixed,
    output logic o_ecc_hard,
    output logic o_par_err
);
    localparam int EW = `DDIC_ECC_W;
    localparam int B = `DDIC_BURST_FIX;
    localparam int SW = $clog2(SLOTS);
    localparam int BW = $clog2(SECT_BYTES);
    localparam int AW = SW + BW;
    localparam int CW = 16;
    localparam logic [CW-1:0] NB = CW'(SECT_BYTES * 8);
    localparam logic [CW-1:0] TOT = CW'(SECT_BYTES * 8 + EW);
    localparam logic [CW-1:0] HB = CW'(`DDIC_HDR_BITS);
    localparam logic [CW-1:0] TRAP_END = CW'(SECT_BYTES * 8 + EW);

    // ----------------------------------------------------------------
    // Storage and check registers
    // ----------------------------------------------------------------
    logic [8:0] mem [SLOTS*SECT_BYTES];
    ddic_state_t st_q;
    logic [CW-1:0] cnt_q;
    logic [`DDIC_ADDR_W-1:0] hdr_q;
    ddic_byte_t sh_q;
    logic [SW:0] slots_q;
    logic [SW-1:0] hslot_q, dslot_q;
    logic [BW-1:0] hbyte_q;
    logic [8*`DDIC_FIX_BYTES-1:0] mask_q;
    logic [CW-1:0] fbyte_q;
    logic [1:0] fk_q;
    logic rd_bad_q;
    int corr_cyc_q;
    logic [EW-1:0] syn_q;

    ddic_lfsr_if #(.W(`DDIC_CRC_W)) crc ();
    ddic_lfsr_if #(.W(EW)) ecc ();
    ddic_lfsr #(.W(`DDIC_CRC_W), .POLY(CRC_POLY)) u_crc (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .lf(crc));
    ddic_lfsr #(.W(EW), .POLY(ECC_POLY)) u_ecc (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .lf(ecc));

    function automatic logic par_of(input ddic_byte_t x);
        par_of = ^x ^ PAR_ODD;
    endfunction

    // ----------------------------------------------------------------
    // Stream decode
    // ----------------------------------------------------------------
    logic tick_h, tick_d, in_data, decide, hdr_ok, avail, trap, hw_hs, rd_hs;
    logic wbit, hbit, wen;
    logic [AW-1:0] daddr, waddr, faddr;
    logic [8:0] dword;
    ddic_byte_t wbyte, rbyte;
    logic [CW-1:0] fb_idx;

    assign tick_h = st_q == DDIC_HDR && i_bit_tick && cnt_q < HB;
    assign tick_d = st_q == DDIC_DATA && i_bit_tick && cnt_q < TOT;
    assign in_data = cnt_q < NB;
    assign decide = st_q == DDIC_HDR && cnt_q == HB;
    assign hdr_ok = i_op_fmt || (crc.q == '0 && hdr_q == i_req_addr);
    assign avail = i_op_write ? slots_q != '0 : slots_q < (SW+1)'(SLOTS);
    assign trap = syn_q[EW-B-1:0] == '0;
    assign daddr = {dslot_q, cnt_q[BW+2:3]};
    assign dword = mem[daddr];
    assign wbit = cnt_q[2:0] == 3'h0 ? dword[7] : sh_q[7];
    assign hbit = cnt_q < CW'(`DDIC_ADDR_W) ? i_req_addr[4'hf - cnt_q[3:0]] : crc.q[`DDIC_CRC_W-1];
    assign rbyte = {sh_q[6:0], i_disk_rd_bit};
    assign fb_idx = fbyte_q + CW'(fk_q);
    assign faddr = {dslot_q, fb_idx[BW-1:0]};
    assign o_host_wr_rdy = i_op_en && i_op_write && slots_q < (SW+1)'(SLOTS);
    assign hw_hs = i_host_wr_vld && o_host_wr_rdy;
    assign rd_hs = o_host_rd_vld && i_host_rd_rdy;
    assign o_busy = st_q != DDIC_IDLE;

    // Header code register: made while formatting, checked while reading
    assign crc.clr = st_q == DDIC_IDLE;
    assign crc.shift = tick_h;
    assign crc.din = i_op_fmt ? hbit : i_disk_rd_bit;
    assign crc.gen = i_op_fmt && cnt_q >= CW'(`DDIC_ADDR_W);
    // Sector code register; its final remainder seeds the burst trap
    assign ecc.clr = st_q == DDIC_IDLE;
    assign ecc.shift = tick_d;
    assign ecc.din = i_op_write ? wbit : i_disk_rd_bit;
    assign ecc.gen = i_op_write && !in_data;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_q <= DDIC_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (st_q)
                DDIC_IDLE: begin
                    cnt_q <= '0;
                    if (i_op_en && i_sector_mark) begin
                        st_q <= DDIC_HDR;
                    end
                end
                DDIC_HDR: begin
                    if (tick_h) begin
                        cnt_q <= cnt_q + 1'b1;
                    end else if (decide) begin
                        cnt_q <= '0;
                        st_q <= (hdr_ok && avail) ? DDIC_DATA : DDIC_IDLE;
                    end
                end
                DDIC_DATA: begin
                    if (tick_d) begin
                        cnt_q <= cnt_q + 1'b1;
                    end else if (cnt_q == TOT) begin
                        cnt_q <= '0;
                        st_q <= (!i_op_write && ecc.q != '0) ? DDIC_CORR : DDIC_IDLE;
                    end
                end
                DDIC_CORR: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (trap) begin
                        st_q <= DDIC_FIX;
                    end else if (cnt_q == TRAP_END) begin
                        st_q <= DDIC_IDLE;
                    end
                end
                DDIC_FIX: begin
                    if (fk_q == 2'(`DDIC_FIX_BYTES - 1)) begin
                        st_q <= DDIC_IDLE;
                    end
                end
                default: begin
                    st_q <= DDIC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Serial shift paths
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            hdr_q <= '0;
            sh_q <= '0;
            o_disk_wr_bit <= 1'b0;
            o_disk_wr_gate <= 1'b0;
        end else begin
            o_disk_wr_gate <= (st_q == DDIC_HDR && i_op_fmt) || (st_q == DDIC_DATA && i_op_write);
            if (tick_h) begin
                // Only the address half is kept; the code half stays in the check register
                if (cnt_q < CW'(`DDIC_ADDR_W)) begin
                    hdr_q <= {hdr_q[`DDIC_ADDR_W-2:0], i_disk_rd_bit};
                end
                o_disk_wr_bit <= hbit;
            end
            if (tick_d && i_op_write) begin
                o_disk_wr_bit <= in_data ? wbit : ecc.q[EW-1];
                sh_q <= cnt_q[2:0] == 3'h0 ? {dword[6:0], 1'b0} : {sh_q[6:0], 1'b0};
            end else if (tick_d && in_data) begin
                sh_q <= rbyte;
            end
        end
    end

    // ----------------------------------------------------------------
    // Burst trapping: pattern aligned into a three-byte window
    // ----------------------------------------------------------------
    // Stepping backwards (divide by x) needs no knowledge of the polynomial's
    // period: the burst's first bit lands in the top bit after TOT-s steps
    always_ff @(posedge i_clk_sys) begin
        if (st_q == DDIC_DATA) begin
            syn_q <= ecc.q;
        end else if (st_q == DDIC_CORR) begin
            syn_q <= syn_q[0] ? {1'b1, syn_q[EW-1:1]} ^ (ECC_POLY >> 1) : syn_q >> 1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        logic [CW-1:0] s;
        s = TOT - cnt_q;
        if (!i_rst_n) begin
            mask_q <= '0;
            fbyte_q <= '0;
            fk_q <= '0;
        end else if (st_q == DDIC_CORR && trap) begin
            mask_q <= {syn_q[EW-1 -: B], {(8*`DDIC_FIX_BYTES-B){1'b0}}} >> s[2:0];
            fbyte_q <= s >> 3;
            fk_q <= '0;
        end else if (st_q == DDIC_FIX) begin
            mask_q <= mask_q << 8;
            fk_q <= fk_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Buffer write port; correction has priority, ops never overlap
    // ----------------------------------------------------------------
    always_comb begin
        wen = 1'b0;
        waddr = '0;
        wbyte = '0;
        if (st_q == DDIC_FIX) begin
            wen = fb_idx < CW'(SECT_BYTES);
            waddr = faddr;
            wbyte = mem[faddr][7:0] ^ mask_q[8*`DDIC_FIX_BYTES-1 -: 8];
        end else if (tick_d && !i_op_write && in_data && cnt_q[2:0] == 3'h7) begin
            wen = 1'b1;
            waddr = daddr;
            wbyte = rbyte;
        end else if (hw_hs) begin
            wen = 1'b1;
            waddr = {hslot_q, hbyte_q};
            wbyte = i_host_wr_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (wen) begin
            mem[waddr] <= {par_of(wbyte), wbyte};
        end
    end

    // ----------------------------------------------------------------
    // Slot accounting; a read sector is counted once clean, repaired, or given up as uncorrectable
    // ----------------------------------------------------------------
    logic host_last, disk_rel, disk_wdone;
    assign host_last = (hw_hs || rd_hs) && hbyte_q == BW'(SECT_BYTES - 1);
    assign disk_wdone = st_q == DDIC_DATA && cnt_q == TOT && i_op_write;
    assign disk_rel = (st_q == DDIC_DATA && cnt_q == TOT && !i_op_write && ecc.q == '0)
        || (st_q == DDIC_CORR && !trap && cnt_q == TRAP_END)
        || (st_q == DDIC_FIX && fk_q == 2'(`DDIC_FIX_BYTES - 1));

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || (!i_op_en && st_q == DDIC_IDLE)) begin
            slots_q <= '0;
            hslot_q <= '0;
            dslot_q <= '0;
            hbyte_q <= '0;
        end else begin
            slots_q <= slots_q + (SW+1)'(host_last && i_op_write) + (SW+1)'(disk_rel)
                - (SW+1)'(host_last && !i_op_write) - (SW+1)'(disk_wdone);
            if (hw_hs || rd_hs) begin
                hbyte_q <= hbyte_q + 1'b1;
            end
            if (host_last) begin
                hslot_q <= hslot_q + 1'b1;
            end
            if (disk_rel || disk_wdone) begin
                dslot_q <= dslot_q + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Host read port: registered data, one idle cycle after each take
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        logic [8:0] w;
        w = mem[{hslot_q, hbyte_q}];
        if (!i_rst_n) begin
            o_host_rd_vld <= 1'b0;
            o_host_rd_data <= '0;
            rd_bad_q <= 1'b0;
        end else begin
            o_host_rd_vld <= i_op_en && !i_op_write && slots_q != '0 && !rd_hs;
            o_host_rd_data <= w[7:0];
            rd_bad_q <= PAR_FITTED && (^w != PAR_ODD);
        end
    end

    // ----------------------------------------------------------------
    // Event pulses
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sect_done <= 1'b0;
            o_hdr_crc_err <= 1'b0;
            o_addr_miss <= 1'b0;
            o_rev_wait <= 1'b0;
            o_ecc_fixed <= 1'b0;
            o_ecc_hard <= 1'b0;
            o_par_err <= 1'b0;
        end else begin
            o_sect_done <= disk_rel || disk_wdone;
            o_hdr_crc_err <= decide && !i_op_fmt && crc.q != '0;
            o_addr_miss <= decide && !i_op_fmt && crc.q == '0 && hdr_q != i_req_addr;
            o_rev_wait <= decide && hdr_ok && !avail;
            o_ecc_fixed <= st_q == DDIC_FIX && fk_q == 2'(`DDIC_FIX_BYTES - 1);
            o_ecc_hard <= st_q == DDIC_CORR && !trap && cnt_q == TRAP_END;
            o_par_err <= (rd_hs && rd_bad_q) || (tick_d && i_op_write && in_data
                && cnt_q[2:0] == 3'h0 && PAR_FITTED && (^dword != PAR_ODD));
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !(st_q == DDIC_CORR || st_q == DDIC_FIX)) begin
            corr_cyc_q <= 0;
        end else begin
            corr_cyc_q <= corr_cyc_q + 1;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_hdr_crc_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (decide && !i_op_fmt && crc.q != '0) |=> o_hdr_crc_err && st_q == DDIC_IDLE)
        else $error("bad header code not flagged");
    a_addr_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (decide && !i_op_fmt && hdr_q != i_req_addr) |=> st_q != DDIC_DATA)
        else $error("data field entered on wrong address");
    a_hdr_code_out: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (decide && i_op_fmt) |-> crc.q == '0)
        else $error("header code not fully shifted out");
    a_ecc_appended: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == DDIC_DATA && i_op_write && cnt_q == TOT) |-> ecc.q == '0 ##1 o_sect_done)
        else $error("sector code not appended");
    a_trap_to_fix: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == DDIC_CORR && trap) |=> st_q == DDIC_FIX [*3] ##1 o_ecc_fixed)
        else $error("trapped burst not repaired");
    a_fix_hidden: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == DDIC_DATA && cnt_q == TOT && !i_op_write && ecc.q != '0)
        |=> $stable(slots_q) throughout (st_q == DDIC_CORR) [*1])
        else $error("faulty sector released before repair");
    a_corr_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        corr_cyc_q <= REV_CYC)
        else $error("correction exceeded one revolution");
    a_par_stored: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wen |=> ^mem[$past(waddr)] == PAR_ODD)
        else $error("stored byte has wrong parity");
    a_wait_no_err: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (decide && hdr_ok && !avail) |=> o_rev_wait && !o_ecc_hard && st_q == DDIC_IDLE)
        else $error("buffer stall not turned into a revolution wait");

    c_read_clean: cover property (@(posedge i_clk_sys) o_sect_done && !i_op_write);
    c_corrected: cover property (@(posedge i_clk_sys) o_ecc_fixed);
    c_rev_wait: cover property (@(posedge i_clk_sys) o_rev_wait);
endmodule

// >>> dv/ddic_disk_model.sv
// Behavioural disk drive that spins one sector past the head and records the write stream
`timescale 1ns/1ps
module ddic_disk_model (
    input wire logic i_clk_sys,
    input wire logic i_disk_wr_bit,
    input wire logic i_disk_wr_gate,
    output logic o_sector_mark,
    output logic o_bit_tick,
    output logic o_rd_bit
);
    // --------------------------------------------------------------
    // Track image and captured write stream
    // --------------------------------------------------------------
    logic trk [0:4183];
    logic wq [$];

    initial begin
        o_sector_mark = 1'b0;
        o_bit_tick = 1'b0;
        o_rd_bit = 1'b0;
    end

    // --------------------------------------------------------------
    // One pass of n bit cells
    // --------------------------------------------------------------
    // A cell every second cycle, with a gap after the header as on a real track.
    // The read line flips between cells so a stale bit is never mistaken for data.
    task automatic spin(input int n);
        @(negedge i_clk_sys);
        o_sector_mark = 1'b1;
        @(negedge i_clk_sys);
        o_sector_mark = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        for (int i = 0; i < n; i++) begin
            if (i == 32) begin
                repeat (6) @(negedge i_clk_sys);
            end
            o_bit_tick = 1'b1;
            o_rd_bit = trk[i];
            @(negedge i_clk_sys);
            o_bit_tick = 1'b0;
            o_rd_bit = ~o_rd_bit;
            if (i_disk_wr_gate === 1'b1) begin
                wq.push_back(i_disk_wr_bit);
            end
            @(negedge i_clk_sys);
        end
    endtask
endmodule

// >>> dv/test_disk_data_integrity_check.sv
// Self-checking bench for the disk data integrity check core
`timescale 1ns/1ps
`include "ddic_consts.svh"
module test_disk_data_integrity_check import ddic_pkg::*; ;
    localparam int REV = 5000;
    localparam logic [15:0] ADR = 16'h3a5c;
    typedef struct {logic [15:0] dadr; logic [31:0] flip; logic ecrc; logic emiss;} ddic_hrow_t;
    typedef struct {int bl; logic efix; logic ehard;} ddic_erow_t;
    ddic_hrow_t hrows [5] = '{'{ADR, 32'h0000_0001, 1'b1, 1'b0}, '{ADR, 32'h8000_0001, 1'b1, 1'b0},
        '{ADR, 32'h4002_0400, 1'b1, 1'b0}, '{ADR ^ 16'h8000, 32'h0, 1'b0, 1'b1},
        '{ADR ^ 16'h0001, 32'h0, 1'b0, 1'b1}};
    ddic_erow_t erows [3] = '{'{0, 1'b0, 1'b0}, '{11, 1'b1, 1'b0}, '{20, 1'b0, 1'b1}};
    logic clk = 1'b0;
    logic rst_n, op_en, op_write, op_fmt, wr_vld, rd_rdy, mark, tick, rbit;
    logic wr_bit, wr_gate, wr_rdy, rd_vld, busy, done, crc_err, miss, rev, fixed, hard, par;
    logic [15:0] req_addr;
    ddic_byte_t wdata, rdata;
    ddic_byte_t rq [$];
    logic [6:0] seen;
    logic par_any = 1'b0;
    int fails, tests_run;

    always #5 clk = ~clk;

    ddic_core #(.REV_CYC(REV)) u_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_op_en(op_en), .i_op_write(op_write),
        .i_op_fmt(op_fmt), .i_req_addr(req_addr), .i_sector_mark(mark), .i_bit_tick(tick),
        .i_disk_rd_bit(rbit), .o_disk_wr_bit(wr_bit), .o_disk_wr_gate(wr_gate),
        .i_host_wr_vld(wr_vld), .i_host_wr_data(wdata), .o_host_wr_rdy(wr_rdy),
        .o_host_rd_vld(rd_vld), .o_host_rd_data(rdata), .i_host_rd_rdy(rd_rdy),
        .o_busy(busy), .o_sect_done(done), .o_hdr_crc_err(crc_err), .o_addr_miss(miss),
        .o_rev_wait(rev), .o_ecc_fixed(fixed), .o_ecc_hard(hard), .o_par_err(par)
    );

    ddic_disk_model u_disk (
        .i_clk_sys(clk), .i_disk_wr_bit(wr_bit), .i_disk_wr_gate(wr_gate),
        .o_sector_mark(mark), .o_bit_tick(tick), .o_rd_bit(rbit)
    );

    // --------------------------------------------------------------
    // Monitors
    // --------------------------------------------------------------
    // Flag pulses last one cycle, so they are gathered here and judged afterwards
    always @(posedge clk) begin
        // Outputs are unknown until the first reset edge, so nothing is gathered before release
        if (rst_n === 1'b1) begin
            seen <= seen | {par, hard, fixed, rev, miss, crc_err, done};
            par_any <= par_any | par;
        end
        if (rd_vld === 1'b1 && rd_rdy === 1'b1) begin
            rq.push_back(rdata);
        end
    end

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk1(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk8(input string nm, input ddic_byte_t e, input ddic_byte_t g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic ddic_byte_t pat(input int b);
        return 8'(b) ^ 8'(b >> 8) ^ 8'h5a;
    endfunction

    function automatic logic [15:0] crc16(input logic [15:0] a);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((a[i] ^ r[15]) ? `DDIC_CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    // Header, data and sector code laid on the track, then a burst flipped in the data
    task automatic build(input logic [15:0] a, input logic [31:0] hf, input int bp, input int bl);
        logic [31:0] h;
        logic [55:0] r;
        ddic_byte_t b;
        h = {a, crc16(a)} ^ hf;
        r = 56'h0;
        for (int i = 0; i < 32; i++) begin
            u_disk.trk[i] = h[31-i];
        end
        for (int k = 0; k < 4096; k++) begin
            b = pat(k / 8);
            u_disk.trk[32+k] = b[7-k%8];
            r = {r[54:0], 1'b0} ^ ((b[7-k%8] ^ r[55]) ? `DDIC_ECC_POLY : 56'h0);
        end
        for (int j = 0; j < 56; j++) begin
            u_disk.trk[4128+j] = r[55-j];
        end
        for (int j = 0; j < bl; j++) begin
            u_disk.trk[32+bp+j] = ~u_disk.trk[32+bp+j];
        end
    endtask

    // Dropping the enable between operations flushes the slots
    task automatic op(input logic wr, input logic fm);
        @(negedge clk);
        op_en = 1'b0;
        @(negedge clk);
        op_en = 1'b1;
        op_write = wr;
        op_fmt = fm;
        seen = 7'h00;
    endtask

    task automatic host_wr(input int n);
        int k;
        k = 0;
        while (k < n) begin
            @(negedge clk);
            wr_vld = 1'b1;
            wdata = pat(k);
            if (wr_rdy === 1'b1) begin
                k++;
            end
        end
        @(negedge clk);
        wr_vld = 1'b0;
    endtask

    task automatic wait_seen(input logic [6:0] m, input int lim);
        for (int w = 0; w < lim && (seen & m) == 7'h00; w++) begin
            @(negedge clk);
        end
        repeat (8) @(negedge clk);
    endtask

    task automatic close_out();
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        close_out();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        {rst_n, op_en, op_write, op_fmt, wr_vld} = 5'h00;
        rd_rdy = 1'b1;
        wdata = 8'h00;
        req_addr = ADR;
        seen = 7'h00;
        fails = 0;
        tests_run = 0;
        repeat (16) @(negedge clk);
        chk1("busy_rst", 1'b0, busy);
        chk1("gate_rst", 1'b0, wr_gate);
        chk1("rd_vld_rst", 1'b0, rd_vld);
        rst_n = 1'b1;
        foreach (hrows[i]) begin
            op(1'b0, 1'b0);
            build(hrows[i].dadr, hrows[i].flip, 0, 0);
            u_disk.spin(32);
            repeat (8) @(negedge clk);
            chk1("hdr_crc_err", hrows[i].ecrc, seen[1]);
            chk1("addr_miss", hrows[i].emiss, seen[2]);
            chk1("busy_after_hdr", 1'b0, busy);
        end
        op(1'b1, 1'b0);
        build(ADR, 32'h0, 0, 0);
        u_disk.spin(32);
        repeat (8) @(negedge clk);
        chk1("rev_wait", 1'b1, seen[3]);
        chk1("no_err_on_wait", 1'b0, seen[1] | seen[2]);
        op(1'b1, 1'b1);
        build(ADR, 32'h0, 0, 0);
        host_wr(512);
        u_disk.wq.delete();
        u_disk.spin(4184);
        wait_seen(7'h01, 20);
        chk1("wr_done", 1'b1, seen[0]);
        chk1("wr_count", 1'b1, u_disk.wq.size() == 4184);
        for (int i = 0; i < 4184 && i < u_disk.wq.size(); i++) begin
            chk1("wr_stream", u_disk.trk[i], u_disk.wq[i]);
        end
        op(1'b1, 1'b0);
        host_wr(2048);
        chk1("wr_rdy_full", 1'b0, wr_rdy);
        foreach (erows[i]) begin
            op(1'b0, 1'b0);
            rq.delete();
            build(ADR, 32'h0, 1000, erows[i].bl);
            u_disk.spin(4184);
            wait_seen(7'h31, REV);
            chk1("ecc_fixed", erows[i].efix, seen[4]);
            chk1("ecc_hard", erows[i].ehard, seen[5]);
            for (int w = 0; w < 3000 && rq.size() < 512; w++) begin
                @(negedge clk);
            end
            chk1("rd_count", 1'b1, rq.size() == 512);
            for (int k = 0; k < 512 && k < rq.size() && !erows[i].ehard; k++) begin
                chk8("rd_data", pat(k), rq[k]);
            end
        end
        chk1("par_err", 1'b0, par_any);
        close_out();
    end
endmodule
